// ### spi_core_defines.svh
// Widths, field codes, reset values and timing counts of the serial port.
// Assumes inclusion by bare name; definitions only.
`ifndef SPI_CORE_DEFINES_SVH
`define SPI_CORE_DEFINES_SVH

// Serial byte framing: eight clocks make sixteen sck edges
`define SPI_EDGE_LAST   5'h0f
`define SPI_EDGE_ZERO   5'h00
// Rate select code that picks the timer one overflow instead of a tap
`define SPI_RATE_TIMER1 3'h7
// Prescaler width in bits
`define SPI_PRESC_W     7
// Reset values
`define SPI_RST_BYTE    8'h00
`define SPI_RST_PRESC   7'h00

`endif

// ### spi_core_pkg.sv
// Types shared by the serial port core and its rate generator.
// Assumes compilation before every other file of the block.
package spi_core_pkg;

	// Master sequencer states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WAIT  = 2'b01,
		ST_SHIFT = 2'b10
	} xfer_state_e;

	typedef logic [2:0] rate_sel_t;
	typedef logic [7:0] byte_t;

endpackage

// ### rate_if.sv
// Carrier between the core and its bit-rate generator.
// Assumes both ends run on mclk.
`timescale 1ns/10ps
`default_nettype none

interface rate_if;
	import spi_core_pkg::*;
	rate_sel_t sel;     // Tap choice or timer one
	logic      t1_ovf;  // Timer one overflow pulse
	logic      tick;    // Half-bit enable pulse

	modport gen  (input sel, input t1_ovf, output tick);
	modport core (output sel, output t1_ovf, input tick);
endinterface : rate_if

`default_nettype wire

// ### spi_rate_gen.sv
// Free-running 7-bit prescaler giving a one-cycle half-bit enable.
// Assumes timer one overflow is a one-cycle pulse on mclk.
`timescale 1ns/10ps
`default_nettype none
`include "spi_core_defines.svh"

module spi_rate_gen (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst_b,
	// Core side
	rate_if.gen       rif
);
	import spi_core_pkg::*;

	logic [`SPI_PRESC_W-1:0] presc;
	logic [`SPI_PRESC_W-1:0] next_presc;
	logic                    tick;
	logic                    next_tick;
	logic [`SPI_PRESC_W-1:0] tap_mask;

	////////////////////////////////////////////////////////////////////////
	// Tap n fires when the low n prescaler bits are all ones
	always_comb begin
		tap_mask   = (`SPI_PRESC_W'(1) << rif.sel) - `SPI_PRESC_W'(1);
		next_presc = presc + `SPI_PRESC_W'(1);
		if (rif.sel == `SPI_RATE_TIMER1) begin
			next_tick = rif.t1_ovf;  // [RULE3]
		end else begin
			next_tick = ((presc & tap_mask) == tap_mask);  // [RULE3]
		end
	end

	// Never reset by the core, so bit slots stay on a fixed grid
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			presc <= `SPI_RST_PRESC;
			tick  <= 1'b0;
		end else begin
			presc <= next_presc;
			tick  <= next_tick;
		end
	end

	assign rif.tick = tick;

endmodule // spi_rate_gen

`default_nettype wire

// ### spi_master_slave_core.sv
// Serial peripheral port core: master or slave byte exchange with
// double-buffered transmit, mode-fault demotion and pin direction override.
// Assumes strobes and levels from mclk logic; pins are asynchronous.
//
// Operation
// [RULE1] As master, drive exactly eight sck clocks per byte.
// [RULE2] Sck pin is output when master, input when slave.
// [RULE3] Rate select picks a prescaler tap or timer one overflow.
// [RULE4] Msb first by default; bit-order select gives lsb first.
// [RULE5] Slave drives miso only while selected; released otherwise.
// [RULE6] External master holds slave select low for a whole message.
// [RULE7] One selected slave and one driving master at a time.
// [RULE8] Master with select disable set: select pin has no effect.
// [RULE9] Master with select disable clear needs select high to continue.
// [RULE10] Clearing select disable leaves a set mode fault set.
// [RULE11] Slave with phase and select disable set is always selected.
// [RULE12] Master seeing select low: drop master bit, pins input, flag fault. Miso is then driven as a selected slave while select stays low.
// [RULE13] After a fault stay slave until software sets master again.
// [RULE14] When enabled, pin directions follow the master bit.
// [RULE15] Master mosi driven only in transfers; pulled up or tristated else.
// [RULE16] Data write loads buffer; empty shifter takes it, sets empty flag.
// [RULE17] Master start waits for the next full bit slot. The code starts on the next half-bit tick.
// [RULE18] Byte end sets complete flag, requests irq, fills receive buffer.
// [RULE19] Empty flag cleared by software or by a data write anytime.
// [RULE20] Queued byte starts next master transfer without software.
// [RULE21] Empty flag interrupts only with irq enable and enhanced bit.
// [RULE22] Master with select ignore set disregards the select pin.
// [RULE23] Phase and polarity choose one of four formats; rate bits rate.
// [RULE24] Fault clears after status read seeing it, then control write.
// [RULE25] Each byte overwrites the receive buffer regardless of reads.
`timescale 1ns/10ps
`default_nettype none
`include "spi_core_defines.svh"

module spi_master_slave_core (
	// Clock and reset
	input  wire logic               mclk,
	input  wire logic               rst_b,
	// Configuration levels and timer one overflow pulse
	input  wire logic               port_enable_bit,
	input  wire spi_core_pkg::rate_sel_t clock_rate_select,
	input  wire logic               bit_order_select,
	input  wire logic               clk_phase,
	input  wire logic               clk_polarity,
	input  wire logic               select_disable,
	input  wire logic               select_ignore,
	input  wire logic               enhanced_interrupt_bit,
	input  wire logic               port_int_enable,
	input  wire logic               pullup_port_mode,
	input  wire logic               timer1_ovf,
	// Software strobes
	input  wire logic               ctrl_wr,
	input  wire logic               ctrl_master,
	input  wire logic               stat_rd,
	input  wire logic               data_wr,
	input  wire spi_core_pkg::byte_t data_in,
	input  wire logic               txe_clr,
	input  wire logic               transfer_complete_flag_clr,
	// Status
	output logic                    master_mode_bit,
	output logic                    mode_fault_flag,
	output logic                    transmit_empty_flag,
	output logic                    transfer_complete_flag,
	output spi_core_pkg::byte_t     rx_data,
	output logic                    irq_req,
	// Pins
	input  wire logic               sck_in,
	output logic                    sck_out,
	output logic                    sck_oe_b,
	input  wire logic               mosi_in,
	output logic                    mosi_out,
	output logic                    mosi_oe_b,
	output logic                    mosi_pullup,
	input  wire logic               miso_in,
	output logic                    miso_out,
	output logic                    miso_oe_b,
	input  wire logic               ss_in
);
	import spi_core_pkg::*;

	// Insert bit b at the end that the bit order fills
	function automatic byte_t shift_in(input byte_t v, input logic b, input logic lsbf);
		shift_in = lsbf ? {b, v[7:1]} : {v[6:0], b};  // [RULE4]
	endfunction

	// Bit presented on the line
	function automatic logic out_bit(input byte_t v, input logic lsbf);
		out_bit = lsbf ? v[0] : v[7];  // [RULE4]
	endfunction

	rate_if rif ();

	spi_rate_gen u_rate (
		.mclk  (mclk),
		.rst_b (rst_b),
		.rif   (rif)
	);

	assign rif.sel    = clock_rate_select;  // [RULE23]
	assign rif.t1_ovf = timer1_ovf;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; only the second stage is read
	logic [1:0] sck_sync, mosi_sync, miso_sync, ss_sync;
	logic       sck_d;
	logic       sck_s, mosi_s, miso_s, ss_s;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sck_sync  <= 2'h0;
			mosi_sync <= 2'h3;
			miso_sync <= 2'h3;
			ss_sync   <= 2'h3;
			sck_d     <= 1'b0;
		end else begin
			sck_sync  <= {sck_sync[0], sck_in};
			mosi_sync <= {mosi_sync[0], mosi_in};
			miso_sync <= {miso_sync[0], miso_in};
			ss_sync   <= {ss_sync[0], ss_in};
			sck_d     <= sck_sync[1];
		end
	end

	assign sck_s  = sck_sync[1];
	assign mosi_s = mosi_sync[1];
	assign miso_s = miso_sync[1];
	assign ss_s   = ss_sync[1];

	////////////////////////////////////////////////////////////////////////
	// Core state
	xfer_state_e state, next_state;
	logic [4:0]  ecnt, next_ecnt;
	byte_t       txbuf, next_txbuf;
	byte_t       txsh, next_txsh;
	byte_t       rxsh, next_rxsh;
	byte_t       next_rx_data;
	logic        txbuf_full, next_txbuf_full;
	logic        sh_loaded, next_sh_loaded;
	logic        sck_lvl, next_sck_lvl;
	logic        mode_fault_flag_arm, next_mode_fault_flag_arm;
	logic        next_master, next_mode_fault_flag, next_txe, next_transfer_complete_flag;

	// Decoded events
	logic  master, slave_sel, slave_act, fault;
	logic  s_lead, s_trail, m_edge, is_lead, is_trail;
	logic  sample, shift_out, done, move, in_bit;
	byte_t rx_shifted;

	always_comb begin
		master    = master_mode_bit & port_enable_bit;
		// Select pin low, or forced selection in three-wire use
		slave_sel = !ss_s | select_ignore | (clk_phase & select_disable);  // [RULE11]
		slave_act = port_enable_bit & !master_mode_bit & slave_sel;
		// Demotion only when the select pin is watched
		fault     = master & !select_ignore & !select_disable & !ss_s;  // [RULE9] [RULE12] [RULE22] [RULE8]
		s_lead    = clk_polarity ? (sck_d & !sck_s) : (!sck_d & sck_s);  // [RULE23]
		s_trail   = clk_polarity ? (!sck_d & sck_s) : (sck_d & !sck_s);
		m_edge    = master & (state == ST_SHIFT) & rif.tick;
		is_lead   = master ? (m_edge & !ecnt[0]) : (slave_act & s_lead);
		is_trail  = master ? (m_edge & ecnt[0]) : (slave_act & s_trail);
		sample    = clk_phase ? is_trail : is_lead;  // [RULE23]
		shift_out = clk_phase ? (is_lead & (ecnt != `SPI_EDGE_ZERO)) : is_trail;
		done      = is_trail & (ecnt == `SPI_EDGE_LAST);  // [RULE1]
		in_bit    = master ? miso_s : mosi_s;
		rx_shifted = sample ? shift_in(rxsh, in_bit, bit_order_select) : rxsh;
		move      = port_enable_bit & txbuf_full & !sh_loaded;
	end

	////////////////////////////////////////////////////////////////////////
	// Next values of the sequencer, buffers and flags
	always_comb begin
		next_state      = state;
		next_ecnt       = ecnt;
		next_txbuf      = txbuf;
		next_txsh       = txsh;
		next_rxsh       = rx_shifted;
		next_rx_data    = rx_data;
		next_txbuf_full = txbuf_full;
		next_sh_loaded  = sh_loaded;
		next_sck_lvl    = sck_lvl;
		next_mode_fault_flag_arm   = mode_fault_flag_arm;
		next_master     = master_mode_bit;
		next_mode_fault_flag       = mode_fault_flag;
		next_txe        = transmit_empty_flag;
		next_transfer_complete_flag       = transfer_complete_flag;

		// Software side: clears first so hardware sets below win
		if (txe_clr) next_txe = 1'b0;  // [RULE19]
		if (transfer_complete_flag_clr) next_transfer_complete_flag = 1'b0;
		if (stat_rd && mode_fault_flag) next_mode_fault_flag_arm = 1'b1;  // [RULE24]
		if (ctrl_wr) begin
			next_master = ctrl_master;  // [RULE13]
			if (mode_fault_flag_arm) begin
				next_mode_fault_flag     = 1'b0;  // [RULE24] [RULE10]
				next_mode_fault_flag_arm = 1'b0;
			end
		end
		if (data_wr) begin
			next_txbuf      = data_in;  // [RULE16]
			next_txbuf_full = 1'b1;
			next_txe        = 1'b0;  // [RULE19]
		end

		// Queued byte drops into an empty shifter
		if (move) begin
			next_txsh      = txbuf;  // [RULE16] [RULE20]
			next_sh_loaded = 1'b1;
			next_txe       = !data_wr;  // A fresh write refills the buffer
			if (!data_wr) next_txbuf_full = 1'b0;
		end

		// Bit engine, shared by both roles
		if (is_lead || is_trail) next_ecnt = ecnt + 5'h01;
		if (shift_out) next_txsh = shift_in(txsh, 1'b1, bit_order_select);
		if (m_edge) next_sck_lvl = !sck_lvl;  // [RULE1]
		if (done) begin
			next_rx_data   = rx_shifted;  // [RULE18] [RULE25]
			next_transfer_complete_flag      = 1'b1;  // [RULE18]
			next_sh_loaded = move;  // A slave may load as its byte ends
			next_ecnt      = `SPI_EDGE_ZERO;
			next_state     = ST_IDLE;
		end

		// Master sequencing
		unique case (state)
			ST_IDLE: begin
				next_sck_lvl = clk_polarity;
				if (master && sh_loaded) next_state = ST_WAIT;
			end
			ST_WAIT: begin
				// Align the first edge to the rate grid
				next_ecnt = `SPI_EDGE_ZERO;
				if (rif.tick) next_state = ST_SHIFT;  // [RULE17]
			end
			ST_SHIFT: begin
				if (!master) next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase

		// Deselected slave or disabled port drops a partial byte
		if (!port_enable_bit || (!master_mode_bit && !slave_sel)) begin
			next_ecnt  = `SPI_EDGE_ZERO;
			next_state = ST_IDLE;
		end

		// Mode fault wins over software and aborts the transfer
		if (fault) begin
			next_master = 1'b0;  // [RULE12] [RULE13]
			next_mode_fault_flag   = 1'b1;  // [RULE12]
			next_state  = ST_IDLE;
			next_ecnt   = `SPI_EDGE_ZERO;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state                  <= ST_IDLE;
			ecnt                   <= `SPI_EDGE_ZERO;
			txbuf                  <= `SPI_RST_BYTE;
			txsh                   <= `SPI_RST_BYTE;
			rxsh                   <= `SPI_RST_BYTE;
			rx_data                <= `SPI_RST_BYTE;
			txbuf_full             <= 1'b0;
			sh_loaded              <= 1'b0;
			sck_lvl                <= 1'b0;
			mode_fault_flag_arm               <= 1'b0;
			master_mode_bit        <= 1'b0;
			mode_fault_flag        <= 1'b0;
			transmit_empty_flag    <= 1'b0;
			transfer_complete_flag <= 1'b0;
		end else begin
			state                  <= next_state;
			ecnt                   <= next_ecnt;
			txbuf                  <= next_txbuf;
			txsh                   <= next_txsh;
			rxsh                   <= next_rxsh;
			rx_data                <= next_rx_data;
			txbuf_full             <= next_txbuf_full;
			sh_loaded              <= next_sh_loaded;
			sck_lvl                <= next_sck_lvl;
			mode_fault_flag_arm               <= next_mode_fault_flag_arm;
			master_mode_bit        <= next_master;
			mode_fault_flag        <= next_mode_fault_flag;
			transmit_empty_flag    <= next_txe;
			transfer_complete_flag <= next_transfer_complete_flag;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drive and interrupt request, registered so outputs are clean
	logic next_sck_out, next_sck_oe_b, next_mosi_out, next_mosi_oe_b;
	logic next_mosi_pullup, next_miso_out, next_miso_oe_b, next_irq;
	logic mosi_drive;

	always_comb begin
		mosi_drive       = master & (state == ST_SHIFT);
		next_sck_oe_b    = !master;  // [RULE2] [RULE14]
		next_sck_out     = master ? sck_lvl : clk_polarity;
		next_mosi_oe_b   = !mosi_drive;  // [RULE15] [RULE14]
		next_mosi_out    = mosi_drive ? out_bit(txsh, bit_order_select) : 1'b1;
		next_mosi_pullup = master & !mosi_drive & pullup_port_mode;  // [RULE15]
		next_miso_oe_b   = !slave_act;  // [RULE5] [RULE14]
		next_miso_out    = slave_act ? out_bit(txsh, bit_order_select) : 1'b1;
		next_irq         = port_int_enable & (transfer_complete_flag | mode_fault_flag
		                   | (enhanced_interrupt_bit & transmit_empty_flag));  // [RULE21] [RULE18]
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sck_out     <= 1'b0;
			sck_oe_b    <= 1'b1;
			mosi_out    <= 1'b1;
			mosi_oe_b   <= 1'b1;
			mosi_pullup <= 1'b0;
			miso_out    <= 1'b1;
			miso_oe_b   <= 1'b1;
			irq_req     <= 1'b0;
		end else begin
			sck_out     <= next_sck_out;
			sck_oe_b    <= next_sck_oe_b;
			mosi_out    <= next_mosi_out;
			mosi_oe_b   <= next_mosi_oe_b;
			mosi_pullup <= next_mosi_pullup;
			miso_out    <= next_miso_out;
			miso_oe_b   <= next_miso_oe_b;
			irq_req     <= next_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence seq_done;
		master && (state == ST_SHIFT) && done;
	endsequence

	sequence seq_move;
		move && !fault;
	endsequence

	AST_BYTE_END: assert property (seq_done |=> (state == ST_IDLE) && transfer_complete_flag) // [RULE1]
		else $error("master byte did not end after the sixteenth edge");
	AST_EDGE_RANGE: assert property ((state == ST_SHIFT) |-> (ecnt <= `SPI_EDGE_LAST)) // [RULE1]
		else $error("edge count ran past eight clocks");
	AST_SCK_DIR: assert property (##1 (sck_oe_b == !$past(master))) // [RULE2]
		else $error("sck direction does not follow master role");
	AST_MISO_QUIET: assert property ((!master_mode_bit && !slave_sel) |=> miso_oe_b) // [RULE5]
		else $error("miso driven while slave not selected");
	AST_FAULT: assert property (fault |=> !master_mode_bit && mode_fault_flag ##1 sck_oe_b) // [RULE12]
		else $error("mode fault did not demote the master");
	AST_MODE_FAULT_FLAG_HOLD: assert property ((mode_fault_flag && !(ctrl_wr && mode_fault_flag_arm)) |=> mode_fault_flag) // [RULE24]
		else $error("mode fault flag cleared without read then control write");
	AST_MOVE: assert property (seq_move |=> sh_loaded && (transmit_empty_flag != $past(data_wr))) // [RULE16]
		else $error("queued byte not moved to shifter");
	AST_TXE_WR: assert property ((data_wr && !move) |=> !transmit_empty_flag) // [RULE19]
		else $error("data write did not clear empty flag");
	AST_RX_LOAD: assert property (done |=> rx_data == $past(rx_shifted)) // [RULE18]
		else $error("receive buffer not loaded at byte end");
	AST_TXE_IRQ: assert property ( // [RULE21]
		(port_int_enable && transmit_empty_flag && enhanced_interrupt_bit) |=> irq_req)
		else $error("empty flag did not request an interrupt");
	AST_START_ALIGN: assert property ( // [RULE17]
		(state == ST_WAIT && !rif.tick && master && !fault) |=> state == ST_WAIT)
		else $error("transfer started off the rate grid");

endmodule // spi_master_slave_core

`default_nettype wire

// ### spi_slave_model.sv
// Slave device model on the far side of the master pins.
// Assumes sck idles low; data captured on rising, changed on falling sck.
`timescale 1ns/10ps
`default_nettype none

module spi_slave_model (
	// Bus pins
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       sel_b,
	output logic            miso,
	// Test side
	input  wire logic       lsb_first,
	input  wire logic [7:0] tx_byte,
	output logic      [7:0] rx_byte,
	output int              n_clk
);
	logic [7:0] tx_sh;

	////////////////////////////////////////////////////////////////
	// Load the reply when selected
	initial n_clk = 0;
	always @(negedge sel_b) begin
		tx_sh = tx_byte;
		n_clk = 0;
	end

	// Capture on the rising edge, counting clocks of the frame
	always @(posedge sck) begin
		if (!sel_b) begin
			n_clk++;
			rx_byte = lsb_first ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
		end
	end

	// Next bit on the falling edge; ones fill in behind
	always @(negedge sck) begin
		if (!sel_b)
			tx_sh = lsb_first ? {1'b1, tx_sh[7:1]} : {tx_sh[6:0], 1'b1};
	end

	// Drives its bit while selected, else a constant one standing in for the pull-up
	assign miso = sel_b ? 1'b1 : (lsb_first ? tx_sh[0] : tx_sh[7]);
endmodule // spi_slave_model

`default_nettype wire

// ### test_spi_master_slave_core.sv
// Self-checking bench of the serial port core with a slave model.
// Assumes strobes are one-cycle pulses given at the falling mclk edge.
`timescale 1ns/10ps
`default_nettype none

module test_spi_master_slave_core;
	import spi_core_pkg::*;
	localparam logic [4:0] CTRL = 5'h10, STAT = 5'h08, DATA = 5'h04;
	localparam logic [4:0] TXEC = 5'h02, SPIFC = 5'h01;
	logic mclk = 0, rst_b, port_enable_bit, bit_order_select, clk_phase;
	logic select_disable, select_ignore, enhanced_interrupt_bit, port_int_enable;
	logic pullup_port_mode, timer1_ovf, ctrl_wr, ctrl_master, stat_rd, data_wr;
	logic txe_clr, transfer_complete_flag_clr, ss_in, slave_sel_b, master_mode_bit, mode_fault_flag;
	logic transmit_empty_flag, transfer_complete_flag, irq_req, sck_out, sck_oe_b;
	logic mosi_out, mosi_oe_b, mosi_pullup, miso, miso_out, miso_oe_b, sck_w, mosi_w;
	rate_sel_t clock_rate_select;
	byte_t     data_in, rx_data, model_tx, model_rx;
	int        n_errors = 0, num_checks = 0, n_clk, cyc = 0, len;
	rate_sel_t rates[3] = '{3'h2, 3'h3, 3'h7};
	int        halves[3] = '{4, 8, 8};

	////////////////////////////////////////////////////////////////
	// Clock, timer overflow every 8 cycles, released pins at idle level
	always #25 mclk = ~mclk;
	always @(negedge mclk) begin
		cyc <= cyc + 1;
		timer1_ovf <= (cyc % 8 == 7);
	end
	assign sck_w = sck_oe_b ? 1'b0 : sck_out;
	assign mosi_w = mosi_oe_b ? 1'b1 : mosi_out;

	spi_master_slave_core dut (.mclk(mclk), .rst_b(rst_b),
		.port_enable_bit(port_enable_bit), .clock_rate_select(clock_rate_select),
		.bit_order_select(bit_order_select), .clk_phase(clk_phase),
		.clk_polarity(1'b0), .select_disable(select_disable),
		.select_ignore(select_ignore), .enhanced_interrupt_bit(enhanced_interrupt_bit),
		.port_int_enable(port_int_enable), .pullup_port_mode(pullup_port_mode),
		.timer1_ovf(timer1_ovf), .ctrl_wr(ctrl_wr), .ctrl_master(ctrl_master),
		.stat_rd(stat_rd), .data_wr(data_wr), .data_in(data_in), .txe_clr(txe_clr),
		.transfer_complete_flag_clr(transfer_complete_flag_clr), .master_mode_bit(master_mode_bit),
		.mode_fault_flag(mode_fault_flag), .transmit_empty_flag(transmit_empty_flag),
		.transfer_complete_flag(transfer_complete_flag), .rx_data(rx_data),
		.irq_req(irq_req), .sck_in(1'b0), .sck_out(sck_out), .sck_oe_b(sck_oe_b),
		.mosi_in(1'b1), .mosi_out(mosi_out), .mosi_oe_b(mosi_oe_b),
		.mosi_pullup(mosi_pullup), .miso_in(miso), .miso_out(miso_out),
		.miso_oe_b(miso_oe_b), .ss_in(ss_in));

	spi_slave_model slave (.sck(sck_w), .mosi(mosi_w), .sel_b(slave_sel_b),
		.miso(miso), .lsb_first(bit_order_select), .tx_byte(model_tx),
		.rx_byte(model_rx), .n_clk(n_clk));

	////////////////////////////////////////////////////////////////
	// Compare and count
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	// One-cycle strobe, order ctrl, stat, data, txe clear, transfer_complete_flag clear
	task pulse(input logic [4:0] s);
		@(negedge mclk);
		{ctrl_wr, stat_rd, data_wr, txe_clr, transfer_complete_flag_clr} = s;
		@(negedge mclk);
		{ctrl_wr, stat_rd, data_wr, txe_clr, transfer_complete_flag_clr} = 5'h00;
	endtask

	// Bounded wait for the complete flag, counting cycles mosi is driven
	task wait_done;
		len = 0;
		for (int i = 0; i < 3000 && transfer_complete_flag !== 1'b1; i++) begin
			@(negedge mclk);
			len += (mosi_oe_b === 1'b0);
		end
		chk(transfer_complete_flag, 8'h01);
	endtask

	task final_report;
		if (n_errors == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Long enough for every scenario several times over
	initial begin
		#(50 * 20000);
		n_errors++;
		final_report();
	end

	////////////////////////////////////////////////////////////////
	// Scenarios
	initial begin
		{rst_b, bit_order_select, clk_phase, select_ignore, enhanced_interrupt_bit} = 5'h00;
		{ctrl_wr, stat_rd, data_wr, txe_clr, transfer_complete_flag_clr, ctrl_master} = 6'h00;
		{port_enable_bit, pullup_port_mode, select_disable, ss_in, slave_sel_b} = 5'h1f;
		{port_int_enable, data_in, model_tx} = {1'b0, 8'h00, 8'h3c};
		clock_rate_select = 3'h2;
		repeat (5) @(negedge mclk);
		rst_b = 1;
		@(negedge mclk);
		chk(sck_oe_b, 8'h01);
		chk(transfer_complete_flag, 8'h00);
		// Master with select disabled: a low select pin must not matter
		ctrl_master = 1;
		ss_in = 0;
		pulse(CTRL);
		repeat (4) @(negedge mclk);
		chk(master_mode_bit, 8'h01);
		chk(sck_oe_b, 8'h00);
		chk(mosi_oe_b, 8'h01);
		chk(mosi_pullup, 8'h01);
		// One byte at each rate: length, count of clocks, both data paths
		for (int r = 0; r < 3; r++) begin
			clock_rate_select = rates[r];
			slave_sel_b = 0; // held low for the whole message
			data_in = 8'ha5 ^ 8'(r);
			pulse(DATA);
			wait_done();
			chk(8'(len >= 16 * halves[r] - 2 && len <= 16 * halves[r] + 2), 8'h01);
			chk(model_rx, data_in);
			chk(rx_data, model_tx);
			chk(8'(n_clk), 8'h08);
			chk(transmit_empty_flag, 8'h01);
			slave_sel_b = 1;
			pulse(SPIFC);
		end
		// Back to back, lsb first, queued byte and interrupt sources
		model_tx = 8'hc3;
		{bit_order_select, port_int_enable, slave_sel_b, clock_rate_select} = 6'h32;
		data_in = 8'h81;
		pulse(DATA);
		data_in = 8'h7e;
		pulse(DATA);
		repeat (2) @(negedge mclk);
		chk(transmit_empty_flag, 8'h00);
		wait_done();
		@(negedge mclk);
		chk(rx_data, 8'hc3);
		chk(irq_req, 8'h01);
		pulse(SPIFC);
		repeat (2) @(negedge mclk);
		chk(irq_req, 8'h00);
		enhanced_interrupt_bit = 1;
		repeat (3) @(negedge mclk);
		chk(irq_req, 8'h01);
		enhanced_interrupt_bit = 0;
		wait_done();
		chk(rx_data, 8'hff);
		chk(model_rx, 8'h7e);
		chk(8'(n_clk), 8'h10);
		chk(transmit_empty_flag, 8'h01);
		pulse(TXEC);
		chk(transmit_empty_flag, 8'h00);
		{slave_sel_b, bit_order_select} = 2'b10;
		pulse(SPIFC);
		// Another master pulls select low
		ss_in = 1;
		repeat (3) @(negedge mclk);
		select_disable = 0;
		repeat (4) @(negedge mclk);
		chk(master_mode_bit, 8'h01);
		ss_in = 0;
		repeat (6) @(negedge mclk);
		chk(master_mode_bit, 8'h00);
		chk(mode_fault_flag, 8'h01);
		chk(sck_oe_b, 8'h01);
		chk(mosi_oe_b, 8'h01);
		chk(irq_req, 8'h01);
		{ss_in, select_disable, ctrl_master} = 3'b110;
		repeat (3) @(negedge mclk);
		select_disable = 0;
		repeat (3) @(negedge mclk);
		chk(mode_fault_flag, 8'h01);
		pulse(CTRL);
		@(negedge mclk);
		chk(mode_fault_flag, 8'h01);
		pulse(STAT);
		pulse(CTRL);
		@(negedge mclk);
		chk(mode_fault_flag, 8'h00);
		chk(master_mode_bit, 8'h00);
		// Master that ignores the select pin
		{select_disable, select_ignore, ctrl_master} = 3'b011;
		pulse(CTRL);
		ss_in = 0;
		repeat (6) @(negedge mclk);
		chk(master_mode_bit, 8'h01);
		chk(mode_fault_flag, 8'h00);
		// Slave: miso driven only while selected, or when always selected
		ss_in = 1;
		repeat (3) @(negedge mclk);
		{select_ignore, ctrl_master} = 2'b00;
		pulse(CTRL);
		data_in = 8'h5a;
		pulse(DATA);
		repeat (5) @(negedge mclk);
		chk(miso_oe_b, 8'h01);
		chk(miso_out, 8'h01);
		chk(sck_oe_b, 8'h01);
		ss_in = 0;
		repeat (5) @(negedge mclk);
		chk(miso_oe_b, 8'h00);
		chk(miso_out, 8'h00);
		{ss_in, clk_phase, select_disable} = 3'b111;
		repeat (5) @(negedge mclk);
		chk(miso_oe_b, 8'h00);
		final_report();
	end
endmodule // test_spi_master_slave_core

`default_nettype wire
